// ---- pkg/ramp_cfg.svh ----
// Register offsets, reset values, ranges and timing constants of the ramp block
`ifndef RAMP_CFG_SVH
`define RAMP_CFG_SVH
`define RTS_OFF_ACCEL1   12'h000
`define RTS_OFF_SWFREQ   12'h010
`define RTS_OFF_SCURVE   12'h014
`define RTS_OFF_STALL    12'h018
`define RTS_OFF_VOLT     12'h01c
`define RTS_OFF_MAXFREQ  12'h020
`define RTS_OFF_TARGET   12'h024
`define RTS_OFF_MFI      12'h028
`define RTS_OFF_STATUS   12'h02c
`define RTS_STRIDE       12'h004
`define RTS_RST_TIME     16'h0064
`define RTS_MAX_TIME     16'hea60
`define RTS_MAX_SWFREQ   16'h07d0
`define RTS_RST_SCURVE   8'h14
`define RTS_MAX_SCURVE   8'hfa
`define RTS_RST_AMODE    2'h1
`define RTS_RST_DMODE    2'h1
`define RTS_MAX_MODE     2'h2
`define RTS_RST_ALEVEL   8'h78
`define RTS_MAX_ALEVEL   8'hc8
`define RTS_RST_VOLT     9'h0c8
`define RTS_MIN_VOLT     9'h09b
`define RTS_MAX_VOLT     9'h0ff
`define RTS_VOLT_SPLIT   9'h190
`define RTS_RST_MAXFREQ  16'h0258
`define RTS_FUNC_TSEL    5'h07
`define RTS_FW_LEVEL     8'h32
`define RTS_OPT_LEVEL    8'h32
`define RTS_SLOW_PCT     16'h0055
`define RTS_PCT_SCALE    16'h0064
`define RTS_DEC_LVL_200  10'h17c
`define RTS_DEC_LVL_HI   10'h2f8
`define RTS_DEC_LVL_LO   10'h294
`define RTS_DEC_MARGIN   10'h014
`define RTS_CLK_NS       20
`define RTS_TICK_NS      1000000
`define RTS_TICK_CYCLES  (`RTS_TICK_NS / `RTS_CLK_NS)
`define RTS_TICKS_DS     24'h000064
`define RTS_TICKS_CS     16'h000a
`define RTS_DEC_ROUND_CS 16'h0014
`define RTS_OPT_SHIFT    10
`define RTS_SHAPE_ONE    17'h10000
`define RTS_SHAPE_MIN    17'h00400
`endif

// ---- pkg/ramp_pkg.sv ----
// Types shared by the ramp block
package ramp_pkg;
  typedef enum logic [1:0] {
    RAMP_STEADY = 2'b00,
    RAMP_ACCEL  = 2'b01,
    RAMP_DECEL  = 2'b10
  } ramp_state_e;
  typedef struct packed {
    ramp_state_e state;
    logic        timeSet2;
    logic        accelSlow;
    logic        accelHold;
    logic        decelHold;
    logic        decelFast;
  } status_s;
endpackage : ramp_pkg

// ---- core/ramp_time_select_stall_guard.sv ----
// Frequency ramp with time-set selection, S-curve rounding and stall prevention
//
// Behaviour
// (R01) Input with function code 7 picks the time set, changeable while running.
// (R02) Select off uses accel/decel time one; on uses accel/decel time two.
// (R03) Automatic: set one at or above switch frequency, set two below it.
// (R04) Switch frequency of zero disables automatic switching.
// (R05) Programmable rounding at accel start and end; fixed 0.2 s on deceleration.
// (R06) Total accel adds half the rounding sum; decel adds 0.2 s.
// (R07) Accel stall mode 1: slow acceleration once current reaches 85 % of level.
// (R08) Accel stall mode 1: stop raising frequency while current exceeds level.
// (R09) Accel stall mode 2: ignore accel time, hold current at 50 % rated.
// (R10) Accel stall mode 0..2 default 1; level 0..200 % default 120 %.
// (R11) In field weakening the accel stall level becomes 50 % rated.
// (R12) Decel stall mode 0: plain deceleration regardless of bus voltage.
// (R13) Decel stall mode 1: freeze frequency while bus voltage at or above level.
// (R14) Decel stall mode 2: may shorten deceleration by bus voltage, never lengthen.
// (R15) Decel level 380 V; 400 V class 760 V or 660 V by input setting.
// (R16) Configurer sets decel stall mode 0 when a braking option is fitted.
// (R17) Decel stall mode accepts 0..2 and resets to 1.
// (R18) Input voltage 155..255 default 200; doubled for the 400 V class.
// (R19) Accel time spans 0 to 100 % max frequency; decel the reverse.
// (R20) Each accel rounding time accepts 0.00..2.50 s, default 0.20 s.
// (R21) Accel stall mode 0 ramps by time alone, ignoring current.
// (R22) Frequency steps once per tick by max frequency over time in ticks.
`timescale 1ns/1ps
`include "ramp_cfg.svh"
`default_nettype none

module ramp_time_select_stall_guard #(
  parameter int unsigned TICK_CYCLES = `RTS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            reset_n,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Drive feedback
  input  wire logic            timeSelectPin,
  input  wire logic [7:0]      outputCurrent,
  input  wire logic [9:0]      busVoltage,
  input  wire logic            fieldWeakening,
  // Modulator reference
  output logic      [15:0]     freqOut,
  output ramp_pkg::status_s    status
);

  // ************************************************************
  // Reset release and pin synchroniser
  // ************************************************************
  logic [1:0] rstPipe;
  logic       rstSync;
  logic [2:0] pinSync;
  logic       pinLevel;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) rstPipe <= 2'h0;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync = rstPipe[1];
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      pinSync  <= 3'h0;
      pinLevel <= 1'b0;
    end else begin
      pinSync <= {pinSync[1:0], timeSelectPin};
      // Only a level seen twice in a row counts, filters one-cycle glitches
      if (pinSync[1] == pinSync[2]) pinLevel <= pinSync[2];
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [15:0] timeReg [4];
  logic [15:0] swFreq;
  logic [7:0]  scStart;
  logic [7:0]  scEnd;
  logic [1:0]  accelMode;
  logic [7:0]  accelLevel;
  logic [1:0]  decelMode;
  logic [8:0]  inVolt;
  logic        class400;
  logic [15:0] maxFreq;
  logic [15:0] target;
  logic [4:0]  mfiFunc;
  wire logic        wrEn = psel & penable & pready & pwrite;
  wire logic        setup = psel & ~penable;
  wire logic [15:0] wLow = pwdata[15:0];
  wire logic [8:0]  wVolt = pwdata[8:0];
  wire logic        wClass = pwdata[16];
  wire logic hitSw    = paddr == `RTS_OFF_SWFREQ;
  wire logic hitSc    = paddr == `RTS_OFF_SCURVE;
  wire logic hitStall = paddr == `RTS_OFF_STALL;
  wire logic hitVolt  = paddr == `RTS_OFF_VOLT;
  wire logic hitMax   = paddr == `RTS_OFF_MAXFREQ;
  wire logic hitTgt   = paddr == `RTS_OFF_TARGET;
  wire logic hitMfi   = paddr == `RTS_OFF_MFI;
  wire logic hitStat  = paddr == `RTS_OFF_STATUS;
  logic [3:0] hitTime;
  // Out-of-range writes are refused and leave the register unchanged
  wire logic okTime  = wLow <= `RTS_MAX_TIME;
  wire logic okSw    = wLow <= `RTS_MAX_SWFREQ;
  wire logic okSc    = pwdata[7:0] <= `RTS_MAX_SCURVE && pwdata[15:8] <= `RTS_MAX_SCURVE; // R20
  wire logic okStall = pwdata[1:0] <= `RTS_MAX_MODE && pwdata[15:8] <= `RTS_MAX_ALEVEL
                       && pwdata[17:16] <= `RTS_MAX_MODE; // R10 R17
  wire logic [8:0] voltLo = wClass ? 9'(`RTS_MIN_VOLT << 1) : `RTS_MIN_VOLT;
  wire logic [8:0] voltHi = wClass ? 9'(`RTS_MAX_VOLT << 1) : `RTS_MAX_VOLT;
  wire logic okVolt  = wVolt >= voltLo && wVolt <= voltHi; // R18
  wire logic okMax   = wLow != 16'h0;
  wire logic anyHit  = (|hitTime) | hitSw | hitSc | hitStall | hitVolt | hitMax
                       | hitTgt | hitMfi | hitStat;
  wire logic badWr   = ((|hitTime) & ~okTime) | (hitSw & ~okSw) | (hitSc & ~okSc)
                       | (hitStall & ~okStall) | (hitVolt & ~okVolt)
                       | (hitMax & ~okMax) | hitStat;
  wire logic errNow  = ~anyHit | (pwrite & badWr);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gTime
      assign hitTime[gi] = paddr == 12'(`RTS_OFF_ACCEL1 + gi * `RTS_STRIDE);
      always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) timeReg[gi] <= `RTS_RST_TIME;
        else if (wrEn && hitTime[gi] && okTime) timeReg[gi] <= wLow;
      end
    end
  endgenerate
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      swFreq     <= 16'h0;
      scStart    <= `RTS_RST_SCURVE; // R20
      scEnd      <= `RTS_RST_SCURVE;
      accelMode  <= `RTS_RST_AMODE; // R10
      accelLevel <= `RTS_RST_ALEVEL;
      decelMode  <= `RTS_RST_DMODE; // R17
      inVolt     <= `RTS_RST_VOLT; // R18
      class400   <= 1'b0;
      maxFreq    <= `RTS_RST_MAXFREQ;
      target     <= 16'h0;
      mfiFunc    <= 5'h0;
    end else if (wrEn) begin
      if (hitSw && okSw) swFreq <= wLow;
      if (hitSc && okSc) begin
        scStart <= pwdata[7:0];
        scEnd   <= pwdata[15:8];
      end
      if (hitStall && okStall) begin
        accelMode  <= pwdata[1:0];
        accelLevel <= pwdata[15:8];
        decelMode  <= pwdata[17:16];
      end
      if (hitVolt && okVolt) begin
        inVolt   <= wVolt;
        class400 <= wClass;
      end
      if (hitMax && okMax) maxFreq <= wLow;
      if (hitTgt) target <= wLow;
      if (hitMfi) mfiFunc <= pwdata[4:0];
    end
  end

  // ************************************************************
  // APB answer: one wait-free access phase
  // ************************************************************
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      `RTS_OFF_SWFREQ:  rdMux = {16'h0, swFreq};
      `RTS_OFF_SCURVE:  rdMux = {16'h0, scEnd, scStart};
      `RTS_OFF_STALL:   rdMux = {14'h0, decelMode, accelLevel, 6'h0, accelMode};
      `RTS_OFF_VOLT:    rdMux = {15'h0, class400, 7'h0, inVolt};
      `RTS_OFF_MAXFREQ: rdMux = {16'h0, maxFreq};
      `RTS_OFF_TARGET:  rdMux = {16'h0, target};
      `RTS_OFF_MFI:     rdMux = {27'h0, mfiFunc};
      `RTS_OFF_STATUS:  rdMux = {9'h0, status, freqOut};
      default: begin
        for (int k = 0; k < 4; k++) begin
          if (hitTime[k]) rdMux = {16'h0, timeReg[k]};
        end
      end
    endcase
  end
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & errNow;
      if (setup && !pwrite) prdata <= rdMux;
    end
  end

  // ************************************************************
  // Time-set selection and stall levels
  // ************************************************************
  wire logic mfiSel  = mfiFunc == `RTS_FUNC_TSEL;
  wire logic autoOn  = swFreq != 16'h0; // R04
  // Terminal assignment takes precedence over frequency-based switching
  wire logic selSet2 = mfiSel ? pinLevel : (autoOn && freqOut < swFreq); // R01 R03
  wire logic [15:0] accT = selSet2 ? timeReg[2] : timeReg[0]; // R02
  wire logic [15:0] decT = selSet2 ? timeReg[3] : timeReg[1]; // R02
  wire logic [7:0]  accLevel = fieldWeakening ? `RTS_FW_LEVEL : accelLevel; // R11
  wire logic [15:0] curScaled = 16'(outputCurrent) * `RTS_PCT_SCALE;
  wire logic [15:0] lvlScaled = 16'(accLevel) * `RTS_SLOW_PCT;
  wire logic accSlow = accelMode == 2'h1 && curScaled >= lvlScaled; // R07
  wire logic accHold = accelMode == 2'h1 && outputCurrent > accLevel; // R08
  wire logic optHold = accelMode == 2'h2 && outputCurrent >= `RTS_OPT_LEVEL; // R09
  wire logic [9:0] decLevel = class400 ? (inVolt >= `RTS_VOLT_SPLIT ? `RTS_DEC_LVL_HI
                              : `RTS_DEC_LVL_LO) : `RTS_DEC_LVL_200; // R15
  wire logic decHold = decelMode == 2'h1 && busVoltage >= decLevel; // R13
  wire logic decFast = decelMode == 2'h2 && busVoltage < decLevel - `RTS_DEC_MARGIN; // R14

  // ************************************************************
  // Ramp step and S-curve shape
  // ************************************************************
  logic [31:0] acc;
  logic [16:0] shape;
  ramp_pkg::ramp_state_e state;
  wire logic [15:0] tgt    = target > maxFreq ? maxFreq : target;
  wire logic [31:0] tgtAcc = {tgt, 16'h0};
  wire logic [31:0] fullAcc = {maxFreq, 16'h0};
  wire logic dirUp   = tgtAcc > acc;
  wire logic dirDown = tgtAcc < acc;
  wire ramp_pkg::ramp_state_e dirState = dirUp ? ramp_pkg::RAMP_ACCEL :
                                         dirDown ? ramp_pkg::RAMP_DECEL :
                                         ramp_pkg::RAMP_STEADY;
  wire logic [15:0] rampT     = dirUp ? accT : decT;
  wire logic [23:0] rampTicks = 24'(rampT) * `RTS_TICKS_DS; // R19
  wire logic [31:0] fullStep  = rampTicks == 24'h0 ? fullAcc
                                : fullAcc / {8'h0, rampTicks}; // R22
  wire logic [31:0] optStep   = fullAcc >> `RTS_OPT_SHIFT;
  wire logic [31:0] dblStep   = fullStep[31] ? fullStep : {fullStep[30:0], 1'b0};
  logic [31:0] baseStep;
  always_comb begin
    baseStep = fullStep; // R12 R21
    if (dirUp) begin
      if (accelMode == 2'h2) baseStep = optHold ? 32'h0 : optStep; // R09
      else if (accHold) baseStep = 32'h0; // R08
      else if (accSlow) baseStep = fullStep >> 1; // R07
    end else if (dirDown) begin
      if (decHold) baseStep = 32'h0; // R13
      else if (decFast) baseStep = dblStep; // R14
    end
  end
  // Rounding lengthens the ramp by half of each rounding time
  wire logic [15:0] decRound   = `RTS_DEC_ROUND_CS * `RTS_TICKS_CS;
  wire logic [15:0] startTicks = dirUp ? 16'(scStart) * `RTS_TICKS_CS : decRound; // R05
  wire logic [15:0] endTicks   = dirUp ? 16'(scEnd) * `RTS_TICKS_CS : decRound; // R05
  wire logic [16:0] startInc   = startTicks == 16'h0 ? `RTS_SHAPE_ONE
                                 : 17'(`RTS_SHAPE_ONE / startTicks);
  wire logic [16:0] endInc     = endTicks == 16'h0 ? `RTS_SHAPE_ONE
                                 : 17'(`RTS_SHAPE_ONE / endTicks);
  wire logic [16:0] curShape = state == dirState ? shape : 17'h0;
  wire logic [48:0] prod     = 49'(baseStep) * 49'(curShape);
  wire logic [31:0] effStep  = prod[47:16];
  wire logic [31:0] remain   = dirUp ? tgtAcc - acc : acc - tgtAcc;
  wire logic [48:0] stepShape = 49'(effStep) * 49'(curShape);
  wire logic [48:0] endProd  = 49'(stepShape[48:16]) * 49'(endTicks);
  wire logic [47:0] endDist  = endProd[48:1];
  wire logic        inEnd    = 48'(remain) <= endDist; // R06
  wire logic [17:0] shapeUp  = 18'(curShape) + 18'(startInc);
  logic [16:0] next_shape;
  logic [31:0] next_acc;
  always_comb begin
    next_shape = curShape;
    if (baseStep != 32'h0) begin
      if (inEnd) next_shape = curShape > endInc + `RTS_SHAPE_MIN ? curShape - endInc
                              : `RTS_SHAPE_MIN; // R05
      else next_shape = shapeUp >= 18'(`RTS_SHAPE_ONE) ? `RTS_SHAPE_ONE : shapeUp[16:0];
    end
    if (remain <= effStep) next_acc = tgtAcc;
    else if (dirUp) next_acc = acc + effStep;
    else next_acc = acc - effStep;
  end

  // ************************************************************
  // Control tick and state
  // ************************************************************
  logic [15:0] tickCnt;
  wire logic   tick = tickCnt == 16'(TICK_CYCLES - 1);
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) tickCnt <= 16'h0;
    else tickCnt <= tick ? 16'h0 : tickCnt + 16'h1;
  end
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      acc     <= 32'h0;
      shape   <= 17'h0;
      state   <= ramp_pkg::RAMP_STEADY;
      freqOut <= 16'h0;
    end else if (tick) begin
      acc     <= next_acc; // R22
      shape   <= next_shape;
      state   <= dirState;
      freqOut <= next_acc[31:16];
    end
  end
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) status <= '0;
    else begin
      status.state     <= state;
      status.timeSet2  <= selSet2;
      status.accelSlow <= dirUp & accSlow;
      status.accelHold <= dirUp & (accHold | optHold);
      status.decelHold <= dirDown & decHold;
      status.decelFast <= dirDown & decFast;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync);
  sequence sSetup;
    psel && !penable;
  endsequence
  sequence sAnswer;
    pready;
  endsequence
  sequence sUpTick;
    tick && dirUp && state == ramp_pkg::RAMP_ACCEL;
  endsequence
  sequence sDownTick;
    tick && dirDown && state == ramp_pkg::RAMP_DECEL;
  endsequence
  a_apb_ready: assert property (sSetup |=> sAnswer ##1 !pready)
    else $error("APB ready not a single cycle after setup");
  a_pin_select: assert property (mfiSel && pinLevel |-> ##1 status.timeSet2) // R01
    else $error("Time-select input ON did not pick set two");
  a_set_times: assert property (!selSet2 |-> accT == timeReg[0] && decT == timeReg[1]) // R02
    else $error("Set one not used with select off");
  a_auto_low: assert property (!mfiSel && autoOn && freqOut < swFreq |=> status.timeSet2) // R03
    else $error("Set two not used below switch frequency");
  a_auto_off: assert property (!mfiSel && !autoOn |-> ##1 !status.timeSet2) // R04
    else $error("Automatic switching active with zero frequency");
  a_accel_hold: assert property (sUpTick and (accelMode == 2'h1 && outputCurrent > accLevel)
    |=> freqOut == $past(freqOut)) // R08
    else $error("Frequency rose above accel stall level");
  a_opt_hold: assert property (sUpTick and (accelMode == 2'h2 && outputCurrent >= 8'h32)
    |=> freqOut == $past(freqOut)) // R09
    else $error("Frequency rose with current at optimum level");
  a_decel_hold: assert property (sDownTick and (decelMode == 2'h1 && busVoltage >= decLevel)
    |=> $stable(freqOut)) // R13
    else $error("Frequency fell during decel stall");
  a_decel_free: assert property (sDownTick and (decelMode == 2'h0 && shape != 17'h0)
    |=> acc < $past(acc)) // R12
    else $error("Deceleration stalled in mode zero");
  a_fw_level: assert property (fieldWeakening |-> accLevel == 8'h32) // R11
    else $error("Field weakening level not fifty percent");
  a_dec_level: assert property (class400 && inVolt < 9'h190 |-> decLevel == 10'h294) // R15
    else $error("Wrong decel stall level for low input");
  a_mode_range: assert property (accelMode <= 2'h2 && decelMode <= 2'h2 && accelLevel <= 8'hc8)
    else $error("Stall setting out of range"); // R10 R17
  a_sc_range: assert property (scStart <= 8'hfa && scEnd <= 8'hfa) // R20
    else $error("Rounding time out of range");
  a_tick_period: assert property (tick |=> !tick [*2]) // R22
    else $error("Control tick repeated too soon");
endmodule : ramp_time_select_stall_guard

`default_nettype wire

// ---- verif/motor_load.sv ----
// Behavioural motor current and bus voltage measurement for the ramp bench
`timescale 1ns/1ps
`default_nettype none

module motor_load (
  // Clock
  input  wire logic       clock,
  // Bench commands
  input  wire logic [7:0] loadPct,
  input  wire logic [9:0] busLevel,
  // Measured values
  output logic      [7:0] outputCurrent,
  output logic      [9:0] busVoltage
);
  // One clock of lag, like a sampled converter
  always_ff @(posedge clock) begin
    outputCurrent <= loadPct;
    busVoltage    <= busLevel;
  end
endmodule : motor_load

`default_nettype wire

// ---- verif/ramp_time_select_stall_guard_tb.sv ----
// Self-checking bench for the ramp block
`timescale 1ns/1ps
`default_nettype none
`include "ramp_cfg.svh"

module ramp_time_select_stall_guard_tb;
  // Short tick keeps second-long ramps cheap
  localparam int TK = 50;
  logic              clock, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic              timeSelectPin, fieldWeakening;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [7:0]        outputCurrent, loadPct;
  logic [9:0]        busVoltage, busLevel;
  logic [15:0]       freqOut, f0;
  ramp_pkg::status_s status;
  int                miscompares, num_checks;

  ramp_time_select_stall_guard #(.TICK_CYCLES(TK)) dut_u (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timeSelectPin(timeSelectPin), .outputCurrent(outputCurrent), .busVoltage(busVoltage),
    .fieldWeakening(fieldWeakening), .freqOut(freqOut), .status(status));
  motor_load load_u (.clock(clock), .loadPct(loadPct), .busLevel(busLevel),
    .outputCurrent(outputCurrent), .busVoltage(busVoltage));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic ok(input string nm, input logic c);
    check(nm, {31'h0, c}, 32'h1);
  endtask : ok

  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'h1, a, d);
    check("write error", {31'h0, err}, {31'h0, e});
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic e);
    apb(1'h0, a, 32'h0);
    check("read data", rd, x);
    check("read error", {31'h0, err}, {31'h0, e});
  endtask : rdc

  task automatic tick(input int n);
    repeat (n * TK) @(posedge clock);
  endtask : tick

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_regs();
    rdc(`RTS_OFF_SCURVE, 32'h1414, 1'h0);
    rdc(`RTS_OFF_STALL, 32'h17801, 1'h0);
    rdc(`RTS_OFF_VOLT, 32'hc8, 1'h0);
    wr(`RTS_OFF_STALL, 32'h17803, 1'h1);
    wr(`RTS_OFF_STALL, 32'h1c901, 1'h1);
    wr(`RTS_OFF_STALL, 32'h37801, 1'h1);
    wr(`RTS_OFF_VOLT, 32'h9a, 1'h1);
    wr(`RTS_OFF_VOLT, 32'h100, 1'h1);
    wr(`RTS_OFF_VOLT, 32'h10135, 1'h1);
    wr(`RTS_OFF_VOLT, 32'h10136, 1'h0);
    wr(`RTS_OFF_SCURVE, 32'hfb, 1'h1);
    wr(`RTS_OFF_STATUS, 32'h0, 1'h1);
    rdc(`RTS_OFF_STALL, 32'h17801, 1'h0);
    rdc(12'h030, 32'h0, 1'h1);
    wr(`RTS_OFF_VOLT, 32'hc8, 1'h0);
  endtask : s_regs

  task automatic s_ramp();
    loadPct <= 8'h96;
    wr(`RTS_OFF_SCURVE, 32'h0, 1'h0);
    wr(`RTS_OFF_ACCEL1, 32'h1, 1'h0);
    wr(`RTS_OFF_ACCEL1 + `RTS_STRIDE, 32'h1, 1'h0);
    wr(`RTS_OFF_STALL, 32'h17800, 1'h0);
    wr(`RTS_OFF_TARGET, 32'h258, 1'h0);
    tick(50);
    ok("mid ramp", freqOut >= 16'h118 && freqOut <= 16'h140);
    tick(60);
    check("ramp end", freqOut, 32'h258);
  endtask : s_ramp

  task automatic s_select();
    wr(`RTS_OFF_MFI, 32'h7, 1'h0);
    timeSelectPin <= 1'h1;
    repeat (8) @(posedge clock);
    ok("pin on", status.timeSet2);
    timeSelectPin <= 1'h0;
    repeat (8) @(posedge clock);
    ok("pin off", !status.timeSet2);
    wr(`RTS_OFF_MFI, 32'h0, 1'h0);
    wr(`RTS_OFF_SWFREQ, 32'h258, 1'h0);
    repeat (2) @(posedge clock);
    ok("at switch", !status.timeSet2);
    wr(`RTS_OFF_SWFREQ, 32'h259, 1'h0);
    repeat (2) @(posedge clock);
    ok("below switch", status.timeSet2);
    wr(`RTS_OFF_SWFREQ, 32'h0, 1'h0);
    repeat (2) @(posedge clock);
    ok("auto off", !status.timeSet2);
  endtask : s_select

  task automatic s_dstall();
    loadPct <= 8'h0;
    busLevel <= 10'h17c;
    wr(`RTS_OFF_TARGET, 32'h0, 1'h0);
    tick(10);
    check("frozen", freqOut, 32'h258);
    ok("hold flag", status.decelHold);
    busLevel <= 10'h17b;
    tick(20);
    ok("resumed", freqOut < 16'h258);
    wr(`RTS_OFF_VOLT, 32'h1018f, 1'h0);
    busLevel <= 10'h294;
    tick(3);
    f0 = freqOut;
    tick(5);
    check("low class hold", freqOut, f0);
    wr(`RTS_OFF_VOLT, 32'h10190, 1'h0);
    tick(5);
    ok("high class runs", freqOut < f0);
    wr(`RTS_OFF_VOLT, 32'hc8, 1'h0);
    wr(`RTS_OFF_STALL, 32'h27800, 1'h0);
    busLevel <= 10'h0;
    tick(2);
    ok("shortened", status.decelFast);
    // Braking option fitted, so the configurer turns deceleration guarding off
    wr(`RTS_OFF_STALL, 32'h07800, 1'h0);
    busLevel <= 10'h384;
    tick(330);
    check("plain decel", freqOut, 32'h0);
  endtask : s_dstall

  task automatic s_astall();
    busLevel <= 10'h0;
    loadPct <= 8'h82;
    wr(`RTS_OFF_STALL, 32'h17801, 1'h0);
    wr(`RTS_OFF_TARGET, 32'h258, 1'h0);
    tick(20);
    check("over level", freqOut, 32'h0);
    ok("accel hold", status.accelHold);
    loadPct <= 8'h6e;
    tick(20);
    ok("slowed", freqOut > 16'h0 && freqOut < 16'h64);
    ok("slow flag", status.accelSlow);
    fieldWeakening <= 1'h1;
    loadPct <= 8'h3c;
    tick(2);
    f0 = freqOut;
    tick(5);
    check("weak field", freqOut, f0);
    fieldWeakening <= 1'h0;
    wr(`RTS_OFF_STALL, 32'h17802, 1'h0);
    tick(2);
    f0 = freqOut;
    tick(10);
    check("current cap", freqOut, f0);
    loadPct <= 8'h28;
    tick(20);
    ok("time ignored", freqOut > f0 && freqOut <= f0 + 16'hc);
    wr(`RTS_OFF_STALL, 32'h07801, 1'h0);
    loadPct <= 8'h0;
    tick(110);
    check("refilled", freqOut, 32'h258);
  endtask : s_astall

  task automatic s_decel();
    wr(`RTS_OFF_TARGET, 32'h0, 1'h0);
    tick(100);
    ok("rounded decel", freqOut != 16'h0);
    tick(230);
    check("decel end", freqOut, 32'h0);
  endtask : s_decel

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, timeSelectPin, fieldWeakening, reset_n} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    loadPct = 8'h0;
    busLevel = 10'h0;
    miscompares = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    reset_n <= 1'h1;
    repeat (4) @(posedge clock);
    s_regs();
    s_ramp();
    s_select();
    s_dstall();
    s_astall();
    s_decel();
    close_out();
  end
endmodule : ramp_time_select_stall_guard_tb

`default_nettype wire
